// ===== rtl/pwip_defines.svh
// Offsets, field positions, reset values for the PWM generator priority bank
// Assumes inclusion by bare name from the package and the design module
`ifndef PWIP_DEFINES_SVH
`define PWIP_DEFINES_SVH

// Register byte offsets on the AXI4-Lite slave
`define PWIP_PRIO_OFFSET 4'h0
`define PWIP_LEVEL_OFFSET 4'h4
`define PWIP_ADDR_W 4

// Field positions (low bit of each 3-bit field)
`define PWIP_GEN6_LSB 12
`define PWIP_GEN5_LSB 8
`define PWIP_GEN4_LSB 4
`define PWIP_GEN3_LSB 0

// Writable bits and reset value of the priority register
`define PWIP_PRIO_MASK 16'h7777
`define PWIP_PRIO_RESET 16'h4444

// Level codes
`define PWIP_LEVEL_OFF 3'h0
`define PWIP_LEVEL_MAX 3'h7

// AXI responses
`define PWIP_RESP_OKAY 2'h0
`define PWIP_RESP_SLVERR 2'h2

`endif

// ===== rtl/pwip_pkg.sv
// Types shared by the PWM generator priority bank
// Assumes the defines header sits beside it
package pwip_pkg;
   `include "pwip_defines.svh"

   // One 3-bit priority level
   typedef logic [2:0] pwip_level_t;

   // Priority register as its fields
   typedef struct packed {
      logic pad15;
      pwip_level_t gen6_irq_level;
      logic pad11;
      pwip_level_t gen5_irq_level;
      logic pad7;
      pwip_level_t gen4_irq_level;
      logic pad3;
      pwip_level_t gen3_irq_level;
   } pwip_prio_t;

   // Write request from the bus
   typedef struct packed {
      logic [`PWIP_ADDR_W-1:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } pwip_wreq_t;

   // Read channel payload
   typedef struct packed {
      logic [31:0] data;
      logic [1:0] resp;
   } pwip_rdat_t;
endpackage

// ===== rtl/pwip_bank.sv
// PWM generator 3..6 interrupt priority bank behind an AXI4-Lite slave
// Assumes a single 125 MHz clock and a master that obeys AXI4-Lite handshakes
`timescale 1ns/1ps
`include "pwip_defines.svh"

module pwip_bank
   import pwip_pkg::*;
(
   input wire logic clk_sys_i, // System clock
   input wire logic reset_n_i, // Async reset, active low
   input wire logic clk_en_i, // Freezes all state when low
   input wire logic [3:0] irq_src_i, // Raw requests, bit0 = gen3 .. bit3 = gen6
   output logic [3:0] irq_req_o, // Requests gated by non-zero level
   output logic [11:0] irq_level_o, // Levels, 3 bits per source, gen3 lowest
   input wire logic [`PWIP_ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [`PWIP_ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready // Read data ready
);

   pwip_prio_t prio;
   logic aw_held;
   logic w_held;
   pwip_wreq_t wreq;
   pwip_rdat_t rdat;
   logic [15:0] next_prio;
   logic [15:0] wmask;
   logic do_write;
   logic [3:0] lvl_nz;
   logic [11:0] lvl_flat;
   logic [15:0] prio_bits;

   assign prio_bits = prio;

   // Accept address and data independently, one write outstanding
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   // Hold write address until paired with data
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_held <= 1'b0;
         wreq.addr <= '0;
      end else if (clk_en_i) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wreq.addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
      end
   end

   // Hold write data until paired with address
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         w_held <= 1'b0;
         wreq.data <= '0;
         wreq.strb <= '0;
      end else if (clk_en_i) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wreq.data <= s_axi_wdata;
            wreq.strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // Byte strobes to bit mask, unimplemented bits never writable
   always_comb begin
      wmask = {{8{wreq.strb[1]}}, {8{wreq.strb[0]}}} & `PWIP_PRIO_MASK;
      next_prio = (prio_bits & ~wmask) | (wreq.data[15:0] & wmask);
   end

   // Priority register, resets to level four in every field
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prio <= `PWIP_PRIO_RESET;
      end else if (clk_en_i && do_write && wreq.addr == `PWIP_PRIO_OFFSET) begin
         prio <= next_prio;
      end
   end

   // Write response; unmapped writes get SLVERR
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PWIP_RESP_OKAY;
      end else if (clk_en_i) begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wreq.addr == `PWIP_PRIO_OFFSET) ? `PWIP_RESP_OKAY : `PWIP_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Per-source level and gating; zero disables, 1..7 are the level itself
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_src
         assign lvl_flat[3*g +: 3] = prio_bits[4*g +: 3];
         assign lvl_nz[g] = (prio_bits[4*g +: 3] != `PWIP_LEVEL_OFF);
      end
   endgenerate

   // Registered request and level outputs
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_req_o <= '0;
         irq_level_o <= '0;
      end else if (clk_en_i) begin
         irq_req_o <= irq_src_i & lvl_nz;
         irq_level_o <= lvl_flat;
      end
   end

   // Read decode: priority register, status view of gated requests
   always_comb begin
      rdat.data = '0;
      rdat.resp = `PWIP_RESP_OKAY;
      unique case (s_axi_araddr)
         `PWIP_PRIO_OFFSET: rdat.data = {16'h0000, prio_bits & `PWIP_PRIO_MASK};
         `PWIP_LEVEL_OFFSET: rdat.data = {28'h0000000, irq_req_o};
         default: rdat.resp = `PWIP_RESP_SLVERR;
      endcase
   end

   // Read data channel
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `PWIP_RESP_OKAY;
      end else if (clk_en_i) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdat.data;
            s_axi_rresp <= rdat.resp;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // pwip_bank

// ===== bench/pwip_bank_assertions.sv
// Port checker for the priority bank
// Assumes binding onto pwip_bank by port name
`timescale 1ns/1ps
module pwip_bank_checker (
   input wire logic clk_sys_i, // Clock
   input wire logic reset_n_i, // Reset
   input wire logic clk_en_i, // Enable
   input wire logic [3:0] irq_src_i, // Raw
   input wire logic [3:0] irq_req_o, // Gated
   input wire logic [11:0] irq_level_o, // Levels
   input wire logic s_axi_awready, // Ready
   input wire logic s_axi_wready, // Ready
   input wire logic s_axi_bvalid, // Valid
   input wire logic s_axi_bready, // Ready
   input wire logic s_axi_arready, // Ready
   input wire logic s_axi_rvalid, // Valid
   input wire logic s_axi_rready, // Ready
   input wire logic [31:0] s_axi_rdata // Data
);
   // One clock, one reset
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_rel;
      $rose(reset_n_i) ##0 clk_en_i;
   endsequence
   a_rst_level: assert property (s_rel |=> irq_level_o == 12'h924)
      else $error("reset level wrong");
   a_gen6_gate: assert property (clk_en_i ##1 irq_level_o[11:9] == 3'h0 |-> !irq_req_o[3])
      else $error("disabled source requests");
   a_gen3_pass: assert property (clk_en_i ##1 irq_level_o[2:0] != 3'h0 |-> irq_req_o[0] == $past(irq_src_i[0]))
      else $error("enabled source lost");
   a_rsvd_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hffff8880) == 32'h0)
      else $error("reserved bits set");
   a_b_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during response");
   a_b_done: assert property (s_axi_bvalid && s_axi_bready && clk_en_i |=> !s_axi_bvalid)
      else $error("write response stuck");
   a_r_done: assert property (s_axi_rvalid && s_axi_rready && clk_en_i |=> !s_axi_rvalid)
      else $error("read response stuck");
endmodule // pwip_bank_checker
bind pwip_bank pwip_bank_checker pwip_bank_checker_inst (.*);

// ===== bench/test_pwm_irq_priority_bank.sv
// Testbench for the priority bank
// Assumes the checker is bound from its own file
`timescale 1ns/1ps
module test_pwm_irq_priority_bank;
   logic clk_sys_i = 1'h0, reset_n_i = 1'h0, clk_en_i = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [3:0] irq_src_i = 4'h0, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf, irq_req_o;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [11:0] irq_level_o;
   int n_errors = 0, checked = 0;
   pwip_bank pwip_bank_inst (.*);
   // 125 MHz clock
   always #4 clk_sys_i = ~clk_sys_i;
   // Value compare
   task chk(input logic [31:0] g, x);
      checked++;
      if (g !== x) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, x);
      end
   endtask
   // One bus access, write when w is high
   task acc(input logic w, input logic [3:0] a, input logic [31:0] d, x, input logic [1:0] xr);
      logic [31:0] g;
      logic [1:0] gr;
      logic aw, wr, ar, rv;
      @(posedge clk_sys_i);
      if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      repeat (50) begin
         @(negedge clk_sys_i);
         {aw, wr, ar} = {s_axi_awready, s_axi_wready, s_axi_arready};
         rv = w ? s_axi_bvalid : s_axi_rvalid;
         g = w ? 32'h0 : s_axi_rdata;
         gr = w ? s_axi_bresp : s_axi_rresp;
         @(posedge clk_sys_i);
         if (aw) s_axi_awvalid <= 1'h0;
         if (wr) s_axi_wvalid <= 1'h0;
         if (ar) s_axi_arvalid <= 1'h0;
         if (rv) break;
      end
      {s_axi_bready, s_axi_rready} <= 2'h0;
      if (!rv) n_errors++;
      chk(g, x);
      chk({30'h0, gr}, {30'h0, xr});
   endtask
   // Verdict
   task summarize;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      #100000;
      n_errors++;
      summarize;
   end
   // Tests
   initial begin
      repeat (16) @(posedge clk_sys_i);
      reset_n_i <= 1'h1;
      irq_src_i <= 4'hb;
      acc(1'h0, 4'h0, 32'h0, 32'h4444, 2'h0);
      chk(irq_level_o, 32'h924);
      acc(1'h1, 4'h0, 32'hffff, 32'h0, 2'h0);
      acc(1'h0, 4'h0, 32'h0, 32'h7777, 2'h0);
      chk(irq_level_o, 32'hfff);
      chk(irq_req_o, 32'hb);
      acc(1'h1, 4'h0, 32'h0217, 32'h0, 2'h0);
      acc(1'h0, 4'h0, 32'h0, 32'h0217, 2'h0);
      chk(irq_level_o, {20'h0, 3'h0, 3'h2, 3'h1, 3'h7});
      chk(irq_req_o, 32'h3);
      acc(1'h0, 4'h4, 32'h0, 32'h3, 2'h0);
      acc(1'h1, 4'h8, 32'h7, 32'h0, 2'h2);
      acc(1'h0, 4'h8, 32'h0, 32'h0, 2'h2);
      acc(1'h0, 4'h0, 32'h0, 32'h0217, 2'h0);
      // Low byte strobe only: generators three and four cleared
      s_axi_wstrb <= 4'h1;
      acc(1'h1, 4'h0, 32'h0, 32'h0, 2'h0);
      s_axi_wstrb <= 4'hf;
      acc(1'h0, 4'h0, 32'h0, 32'h0200, 2'h0);
      // Clock enable low freezes the request path
      clk_en_i <= 1'h0;
      irq_src_i <= 4'h4;
      repeat (3) @(posedge clk_sys_i);
      chk(irq_req_o, 32'h0);
      clk_en_i <= 1'h1;
      repeat (2) @(posedge clk_sys_i);
      chk(irq_req_o, 32'h4);
      // Reset in mid-run restores the default levels
      reset_n_i <= 1'h0;
      repeat (2) @(posedge clk_sys_i);
      reset_n_i <= 1'h1;
      acc(1'h0, 4'h0, 32'h0, 32'h4444, 2'h0);
      chk(irq_level_o, 32'h924);
      summarize;
   end
endmodule // test_pwm_irq_priority_bank
